// ==== core/codec_ctl_bank.sv ====
// Control register bank of the codec: pointer, identity, power, modes
//
// Operation
// - Pointer advances after access when enabled
// - Low pointer bits select register; reset 01
// - Address 01 returns part and revision
// - Receiver reset on 01/11, runs on 00
// - Host changes sleep bits while muted
// - Either receiver bit set holds receiver in reset
// - ADC sleep bit holds ADC in reset
// - Host sets the test sleep bit
// - Each DAC pair sleep bit resets pair
// - Global sleep resets to one, keeps registers
// - Codec speed field selects rate range
// - Aux port speed field, same encoding
// - ADC route code steers output pins
// - DAC de-emphasis at detected rates, or at the manual rate when lock is forced
// - Forced lock uses manual rate field
// - Receiver de-emphasis follows channel status
// - Format field selects LJ, I2S, RJ
// - Registers read-write except identity
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "codec_ctl_regs.svh"
module codec_ctl_bank
  import codec_ctl_pkg::*;
#(
  parameter logic [3:0] PART_CODE = 4'hA, // Arbitrary value
  parameter logic [3:0] SILICON_REV = 4'h5 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control port
  ctl_link_if.dev link,
  // Rate detector and channel status
  input wire codec_ctl_pkg::deemph_t detected_rate,
  input wire logic rx_emphasis,
  input wire codec_ctl_pkg::deemph_t manual_rate_sel,
  input wire logic force_lock,
  // Power controls
  output logic receiver_reset,
  output logic adc_reset,
  output logic [2:0] dac_pair_reset,
  output logic global_sleep,
  output logic test_sleep_bit,
  // Mode controls
  output codec_ctl_pkg::speed_t codec_speed_sel,
  output codec_ctl_pkg::speed_t aux_port_speed_sel,
  output logic adc_on_codec_data_out,
  output logic adc_uses_aux_clock,
  output logic rx_on_aux_data_out,
  output codec_ctl_pkg::format_t serial_format_sel,
  output codec_ctl_pkg::deemph_t dac_deemph_filter,
  output codec_ctl_pkg::deemph_t rx_deemph_filter
);
  import codec_ctl_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ptr_auto_advance;
    logic [`PTR_W-1:0] ptr;
    logic [7:0] power;
    logic [7:0] mode;
    logic [7:0] format;
    logic [7:0] rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [7:0] read_val;
  logic [1:0] rx_bits;
  logic [1:0] route;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    unique case (state_reg.ptr)
      `ADDR_IDENTITY: read_val = {PART_CODE, SILICON_REV};
      `ADDR_POWER: read_val = state_reg.power;
      `ADDR_MODE: read_val = state_reg.mode;
      `ADDR_FORMAT: read_val = state_reg.format;
      default: read_val = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rdata = 8'h00;
    if (link.ptr_wr) begin
      state_next.ptr_auto_advance = link.ptr_data[`PTR_ADV_BIT];
      state_next.ptr = link.ptr_data[`PTR_W-1:0];
    end else if (link.reg_wr || link.reg_rd) begin
      if (link.reg_wr) begin
        // Identity falls to default: writes leave no trace
        unique case (state_reg.ptr)
          `ADDR_POWER: state_next.power = link.wdata;
          `ADDR_MODE: state_next.mode = link.wdata;
          `ADDR_FORMAT: state_next.format = link.wdata;
          default: state_next.power = state_reg.power;
        endcase
      end else begin
        state_next.rdata = read_val;
      end
      if (state_reg.ptr_auto_advance) begin
        state_next.ptr = state_reg.ptr + `PTR_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg.ptr_auto_advance <= `ADV_RESET;
      state_reg.ptr <= `PTR_RESET;
      state_reg.power <= `POWER_RESET;
      state_reg.mode <= `MODE_RESET;
      state_reg.format <= `FORMAT_RESET;
      state_reg.rdata <= 8'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  assign link.rdata = state_reg.rdata;
  assign rx_bits = state_reg.power[`RX_SLEEP_HI:`RX_SLEEP_LO];
  // Reserved 10 (the reset code) is taken as reset, the safe side
  assign receiver_reset = (rx_bits != 2'h0);
  assign adc_reset = state_reg.power[`ADC_SLEEP_BIT];
  assign dac_pair_reset = state_reg.power[`DAC_SLEEP_LO+:3];
  assign global_sleep = state_reg.power[`GLOBAL_SLEEP_BIT];
  assign test_sleep_bit = state_reg.power[`TEST_SLEEP_BIT];
  assign codec_speed_sel = speed_t'(state_reg.mode[`CODEC_SPEED_LO+:2]);
  assign aux_port_speed_sel = speed_t'(state_reg.mode[`AUX_SPEED_LO+:2]);
  assign route = state_reg.mode[`ADC_ROUTE_LO+:2];
  assign adc_on_codec_data_out = (route == 2'h0) || (route == 2'h1);
  assign adc_uses_aux_clock = (route == 2'h1) || (route == 2'h2);
  assign rx_on_aux_data_out = adc_on_codec_data_out;
  assign serial_format_sel = format_t'(state_reg.format[`FORMAT_LO+:2]);

  // ----------------------------------------------------------------
  // De-emphasis selection
  // ----------------------------------------------------------------
  deemph_sel dac_sel (
    .enable(state_reg.mode[`DAC_DEEMPH_BIT]),
    .force_lock(force_lock),
    .manual_rate_sel(manual_rate_sel),
    .detected_rate(detected_rate),
    .emph_request(1'b1),
    .filter_sel(dac_deemph_filter)
  );

  deemph_sel rx_sel (
    .enable(state_reg.mode[`RX_DEEMPH_BIT]),
    .force_lock(force_lock),
    .manual_rate_sel(manual_rate_sel),
    .detected_rate(detected_rate),
    .emph_request(rx_emphasis),
    .filter_sel(rx_deemph_filter)
  );
endmodule : codec_ctl_bank

// ==== core/codec_ctl_host.sv ====
// Host end: turns software commands into control port accesses
`timescale 1ns/1ps
`include "codec_ctl_regs.svh"
module codec_ctl_host
  import codec_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Software port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  // Control port
  ctl_link_if.host link
);
  import codec_ctl_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ptr_wr;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] out_data;
    logic rd_pend;
    logic [7:0] last_rd;
    logic [31:0] sw_rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.ptr_wr = 1'b0;
    state_next.reg_wr = 1'b0;
    state_next.reg_rd = 1'b0;
    state_next.sw_rdata = 32'h0;
    state_next.rd_pend = state_reg.reg_rd;
    if (state_reg.rd_pend) begin
      state_next.last_rd = link.rdata;
    end
    // Command word: [9:8] kind, [7:0] pointer byte or write data
    if (sw_wr && sw_addr == `CTL_ADDR_CMD) begin
      state_next.out_data = sw_wdata[7:0];
      // Pointer byte bit 7 keeps auto advance; the bank handles
      state_next.ptr_wr = (sw_wdata[9:8] == `CMD_PTR);
      state_next.reg_wr = (sw_wdata[9:8] == `CMD_WRITE);
      state_next.reg_rd = (sw_wdata[9:8] == `CMD_READ);
    end
    if (sw_rd) begin
      unique case (sw_addr)
        `CTL_ADDR_DATA: state_next.sw_rdata = {24'h0, state_reg.last_rd};
        `CTL_ADDR_STATUS: state_next.sw_rdata = {31'h0, state_reg.rd_pend};
        default: state_next.sw_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Software is trusted values
  assign link.ptr_wr = state_reg.ptr_wr;
  assign link.reg_wr = state_reg.reg_wr;
  assign link.reg_rd = state_reg.reg_rd;
  assign link.ptr_data = state_reg.out_data;
  assign link.wdata = state_reg.out_data;
  assign sw_rdata = state_reg.sw_rdata;
endmodule : codec_ctl_host

// ==== core/deemph_sel.sv ====
// De-emphasis filter selection from enable, lock force and rate
`timescale 1ns/1ps
module deemph_sel
  import codec_ctl_pkg::*;
(
  // Control
  input wire logic enable,
  input wire logic force_lock,
  input wire codec_ctl_pkg::deemph_t manual_rate_sel,
  // Detected rate and emphasis request
  input wire codec_ctl_pkg::deemph_t detected_rate,
  input wire logic emph_request,
  // Result
  output codec_ctl_pkg::deemph_t filter_sel
);
  always_comb begin
    if (!enable || !emph_request) begin
      filter_sel = DEEMPH_OFF;
    end else if (force_lock) begin
      // Reserved manual code 00 leaves the filter off
      filter_sel = manual_rate_sel;
    end else begin
      // Detector reports 00 for any rate other than 32/44.1/48 kHz
      filter_sel = detected_rate;
    end
  end
endmodule : deemph_sel

// ==== dv/codec_core_control_registers_tb.sv ====
// Bench driving the control bank through its host end
`timescale 1ns/1ps
module codec_core_control_registers_tb;
  import codec_ctl_pkg::*;
  localparam logic [3:0] PART = 4'hC; // Arbitrary value
  localparam logic [3:0] REV = 4'h9; // Arbitrary value
  // Receiver and ADC bits only move while global sleep is still set
  localparam logic [7:0] PW [6] = '{8'h41, 8'hE5, 8'hF4, 8'hFB, 8'h1B, 8'h1A};
  localparam logic [7:0] MD [4] = '{8'h00, 8'h54, 8'hA8, 8'hF3};
  logic clk, nrst, sw_wr, sw_rd, rx_emphasis, force_lock;
  logic [3:0] sw_addr;
  logic [31:0] sw_wdata, sw_rdata;
  deemph_t detected_rate, manual_rate_sel;
  deemph_t dac_deemph_filter, rx_deemph_filter;
  logic receiver_reset, adc_reset, global_sleep, test_sleep_bit;
  logic adc_on_codec_data_out, adc_uses_aux_clock, rx_on_aux_data_out;
  logic [2:0] dac_pair_reset;
  speed_t codec_speed_sel, aux_port_speed_sel;
  format_t serial_format_sel;
  logic [6:0] pwr_o, mode_o;
  logic [3:0] dm_o;
  logic [7:0] m;
  logic [1:0] e;
  int n_mismatch, checked, cycles;
  assign pwr_o = {receiver_reset, adc_reset, test_sleep_bit, dac_pair_reset,
    global_sleep};
  assign mode_o = {codec_speed_sel, aux_port_speed_sel, adc_on_codec_data_out,
    adc_uses_aux_clock, rx_on_aux_data_out};
  assign dm_o = {dac_deemph_filter, rx_deemph_filter};
  // ----
  // Both ends joined by the link
  // ----
  ctl_link_if link ();
  codec_ctl_host codec_ctl_host_i (.clk, .nrst, .sw_addr, .sw_wdata, .sw_wr,
    .sw_rd, .sw_rdata, .link(link.host));
  codec_ctl_bank #(.PART_CODE(PART), .SILICON_REV(REV)) codec_ctl_bank_i (
    .clk, .nrst, .link(link.dev), .detected_rate, .rx_emphasis,
    .manual_rate_sel, .force_lock, .receiver_reset, .adc_reset,
    .dac_pair_reset, .global_sleep, .test_sleep_bit, .codec_speed_sel,
    .aux_port_speed_sel, .adc_on_codec_data_out, .adc_uses_aux_clock,
    .rx_on_aux_data_out, .serial_format_sel, .dac_deemph_filter,
    .rx_deemph_filter);
  codec_ctl_asserts #(.PART_CODE(PART), .SILICON_REV(REV))
    codec_ctl_asserts_i (.clk, .nrst, .ptr_wr(link.ptr_wr),
    .ptr_data(link.ptr_data), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd),
    .wdata(link.wdata), .rdata(link.rdata));
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] x, input logic [31:0] s,
    input string nm);
    checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic cmd(input logic [9:0] a, input logic [9:0] b = 10'h0,
    input int n = 1);
    @(posedge clk);
    sw_addr <= 4'h0;
    sw_wdata <= {22'h0, a};
    sw_wr <= 1'h1;
    if (n == 2) begin
      @(posedge clk);
      sw_wdata <= {22'h0, b};
    end
    @(posedge clk);
    sw_wr <= 1'h0;
    repeat (4) @(posedge clk);
    #1;
  endtask : cmd
  task automatic sread(input logic [3:0] a, input logic [31:0] x);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'h1;
    @(posedge clk);
    sw_rd <= 1'h0;
    #1 chk(x, sw_rdata, "sw_rdata");
  endtask : sread
  task automatic rd(input logic [7:0] x);
    cmd({2'h3, 8'h00});
    sread(4'h1, {24'h0, x});
  endtask : rd
  task automatic pw_chk(input logic [7:0] b);
    chk(32'({|b[7:6], b[5:0]}), 32'(pwr_o), "power");
  endtask : pw_chk
  task automatic give_verdict();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  // ----
  // Clock, time limit and sequence
  // ----
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    {nrst, sw_wr, sw_rd, sw_addr, sw_wdata, rx_emphasis, force_lock} = '0;
    detected_rate = DEEMPH_OFF;
    manual_rate_sel = DEEMPH_OFF;
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    #1 pw_chk(8'h81);
    chk(32'(FMT_I2S), 32'(serial_format_sel), "format");
    rd({PART, REV});
    rd(8'h81);
    rd(8'h00);
    rd(8'h40);
    rd(8'h00);
    cmd({2'h1, 8'h02});
    foreach (PW[i]) begin
      cmd({2'h2, PW[i]});
      pw_chk(PW[i]);
      rd(PW[i]);
    end
    cmd({2'h1, 8'h03});
    foreach (MD[i]) begin
      m = MD[i];
      cmd({2'h2, m});
      chk(32'({m[7:4], !m[3], |m[3:2], !m[3]}), 32'(mode_o), "mode");
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      force_lock <= k[2];
      manual_rate_sel <= deemph_t'(k[1:0]);
      detected_rate <= deemph_t'(k[2] ? ~k[1:0] : k[1:0]);
      rx_emphasis <= k[0] ^ k[1];
      e = k[1:0] & {2{k[0] ^ k[1]}};
      #1;
      chk(32'({k[1:0], e}), 32'(dm_o), "deemph");
    end
    cmd({2'h2, 8'h40});
    chk(32'h0, 32'(dm_o), "deemph off");
    cmd({2'h1, 8'h04});
    for (int f = 0; f < 3; f++) begin
      cmd({2'h2, f[1:0], 6'h00});
      chk(32'(f), 32'(serial_format_sel), "format");
    end
    cmd({2'h1, 8'h81});
    cmd({2'h2, 8'h5A});
    cmd({2'h2, 8'h10});
    pw_chk(8'h10);
    cmd({2'h1, 8'h81});
    rd({PART, REV});
    cmd({2'h3, 8'h00}, {2'h3, 8'h00}, 2);
    sread(4'h1, 32'h40);
    sread(4'h2, 32'h0);
    sread(4'h3, 32'h0);
    give_verdict();
  end
endmodule : codec_core_control_registers_tb

// ==== dv/codec_ctl_asserts.sv ====
// Checks on the control port link between host and bank
`timescale 1ns/1ps
module codec_ctl_asserts #(
  parameter logic [3:0] PART_CODE = 4'hA, // Arbitrary value
  parameter logic [3:0] SILICON_REV = 4'h5 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link
  input wire logic ptr_wr,
  input wire logic [7:0] ptr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  // ----
  // Shadow of pointer and registers
  // ----
  logic [6:0] ptr_q;
  logic adv_q;
  logic [7:0] pw_q, md_q, fm_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {adv_q, ptr_q} <= 8'h81;
      pw_q <= 8'h81;
      md_q <= 8'h00;
      fm_q <= 8'h40;
    end else if (ptr_wr) begin
      {adv_q, ptr_q} <= ptr_data;
    end else if (reg_wr || reg_rd) begin
      if (reg_wr && ptr_q == 7'h02) pw_q <= wdata;
      if (reg_wr && ptr_q == 7'h03) md_q <= wdata;
      if (reg_wr && ptr_q == 7'h04) fm_q <= wdata;
      if (adv_q) ptr_q <= ptr_q + 7'h01;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_read(logic [6:0] a);
    reg_rd && !ptr_wr && ptr_q == a;
  endsequence
  sequence s_adv_pair;
    reg_rd && !ptr_wr && adv_q && ptr_q == 7'h02 ##1 reg_rd && !ptr_wr;
  endsequence
  a_id_value: assert property (
    s_read(7'h01) |=> rdata == {PART_CODE, SILICON_REV}) else $error("bad id");
  a_power_read: assert property (
    s_read(7'h02) |=> rdata == pw_q) else $error("bad power read");
  a_mode_read: assert property (
    s_read(7'h03) |=> rdata == md_q) else $error("bad mode read");
  a_format_read: assert property (
    s_read(7'h04) |=> rdata == $past(fm_q)) else $error("bad format read");
  a_unmapped_zero: assert property (
    reg_rd && !ptr_wr && (ptr_q == 7'h00 || ptr_q > 7'h04) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ptr_advance: assert property (
    s_adv_pair |=> rdata == md_q) else $error("pointer did not advance");
  a_rdata_idle: assert property (
    !reg_rd |=> rdata == 8'h00) else $error("rdata not zero when idle");
  a_one_strobe: assert property (
    $onehot0({ptr_wr, reg_wr, reg_rd})) else $error("strobes overlap");
endmodule : codec_ctl_asserts

// ==== include/codec_ctl_pkg.sv ====
// Types shared by the control bank and its host
package codec_ctl_pkg;
  typedef enum logic [1:0] {
    SPEED_SINGLE = 2'h0,
    SPEED_DOUBLE = 2'h1,
    SPEED_QUAD = 2'h2,
    SPEED_RSVD = 2'h3
  } speed_t;
  typedef enum logic [1:0] {
    FMT_LEFT = 2'h0,
    FMT_I2S = 2'h1,
    FMT_RIGHT = 2'h2,
    FMT_RSVD = 2'h3
  } format_t;
  typedef enum logic [1:0] {
    DEEMPH_OFF = 2'h0,
    DEEMPH_32K = 2'h1,
    DEEMPH_44K1 = 2'h2,
    DEEMPH_48K = 2'h3
  } deemph_t;
endpackage : codec_ctl_pkg

// ==== include/codec_ctl_regs.svh ====
// Register offsets, field positions and reset values of the control bank
`ifndef CODEC_CTL_REGS_SVH
`define CODEC_CTL_REGS_SVH

`define PTR_W 7
`define PTR_RESET 7'h01
`define ADV_RESET 1'h1
`define ADDR_IDENTITY 7'h01
`define ADDR_POWER 7'h02
`define ADDR_MODE 7'h03
`define ADDR_FORMAT 7'h04
`define POWER_RESET 8'h81
`define MODE_RESET 8'h00
`define FORMAT_RESET 8'h40
`define PTR_ADV_BIT 7
`define RX_SLEEP_HI 7
`define RX_SLEEP_LO 6
`define ADC_SLEEP_BIT 5
`define TEST_SLEEP_BIT 4
`define DAC_SLEEP_LO 1
`define GLOBAL_SLEEP_BIT 0
`define CODEC_SPEED_LO 6
`define AUX_SPEED_LO 4
`define ADC_ROUTE_LO 2
`define DAC_DEEMPH_BIT 1
`define RX_DEEMPH_BIT 0
`define FORMAT_LO 6
`define CMD_PTR 2'h1
`define CMD_WRITE 2'h2
`define CMD_READ 2'h3
`define CTL_ADDR_CMD 4'h0
`define CTL_ADDR_DATA 4'h1
`define CTL_ADDR_STATUS 4'h2

`endif

// ==== include/ctl_link_if.sv ====
// Control port link between host and register bank
`timescale 1ns/1ps
interface ctl_link_if;
  logic ptr_wr;
  logic [7:0] ptr_data;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport host (output ptr_wr, output ptr_data, output reg_wr,
                output reg_rd, output wdata, input rdata);
  modport dev (input ptr_wr, input ptr_data, input reg_wr,
               input reg_rd, input wdata, output rdata);
endinterface : ctl_link_if
